/* hw/sacl_device.sv */
// Converter end of the serial link: addressing, settling, 8-bit
// successive approximation and result replay.
// Assumes link pins are asynchronous to sys_clk and the link clock
// is slow enough for three system cycles per edge to be seen.
//
// Behaviour
// - Host holds select low whole transaction.
// - First one on rising edge starts.
// - Two to four channel bits follow start.
// - Channel word picks mode, pair, polarity.
// - Half period idle before conversion begins.
// - Active status rises at settling start.
// - Data input ignored after channel assigned.
// - Output driven zero after settling period.
// - Comparator bits out on falling edges.
// - One when input reaches or exceeds trial level.
// - Conversion finishes after nine periods.
// - Active status drops half period later.
// - All result bits held for replay.
// - No-enable variant replays low first automatically.
// - Output low after replay until deselect.
// - Enable high holds low bit steady.
// - Enable low shifts result low first.
// - Single-channel variant has no replay.
// - Select high clears all sequencer registers.
// - New conversion needs fresh select fall.
// - Positive input sampled while output undriven, negative while leading zero driven.
// - Positive sampled, negative half period later.
// - Code step is reference over 256.
`timescale 1ns/1ps
`default_nettype none
module sacl_device #(
   parameter sacl_pkg::sacl_variant_t VARIANT = sacl_pkg::SACL_VAR_SE,
   parameter int MUX_BITS = sacl_pkg::SACL_MUX_MAX
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   sacl_link_if.device link,
   input wire logic [sacl_pkg::SACL_NUM_CH-1:0][sacl_pkg::SACL_RES_BITS-1:0] analog_code,
   output logic [sacl_pkg::SACL_RES_BITS-1:0] conv_result
);
   import sacl_pkg::*;

   // ************************************************************
   // Local types and constants
   // ************************************************************
   // The single-channel part takes no channel word at all
   localparam int MW = (VARIANT == SACL_VAR_SINGLE) ? 0 : MUX_BITS;
   localparam logic [3:0] MW_LAST = 4'(MW - 1);
   localparam logic [3:0] LAST_BIT = 4'(SACL_RES_BITS - 1);
   localparam logic [3:0] REPLAY_END = 4'(SACL_REPLAY_BITS + 1);
   localparam logic [2:0] ALIGN = 3'(SACL_MUX_MAX - MW);
   localparam sacl_code_t MSB_MASK = 8'h80;
   // Idle pin levels: select high, clock low, data low, enable high.
   // Matching them keeps a false link clock edge from following reset
   localparam logic [3:0] PIN_IDLE = 4'h9;

   typedef enum {ST_IDLE, ST_ADDR, ST_SETTLE, ST_CONV, ST_TAIL, ST_LOW} sacl_state_t;

   // Channel index from pair select and polarity bit
   function automatic logic [2:0] sacl_chan(input logic [1:0] sel, input logic odd);
      sacl_chan = {sel, odd};
   endfunction : sacl_chan

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // Order: select, clock, data in, shift enable
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic sclk_prev_q;
   logic [3:0] sync1_d;
   logic [3:0] sync2_d;
   logic sclk_prev_d;

   // Two stages before any logic; only the second feeds the edge finder
   always_comb begin
      sync1_d = {link.conv_select_n, link.sclk, link.serial_in, link.lsb_shift_enable_n};
      sync2_d = sync1_q;
      sclk_prev_d = sync2_q[2];
   end

   // Select idles high so the device starts released
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync1_q <= PIN_IDLE;
         sync2_q <= PIN_IDLE;
         sclk_prev_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sclk_prev_q <= sclk_prev_d;
      end
   end

   logic cs_n_s;
   logic di_s;
   logic se_n_s;
   logic rise;
   logic fall;
   assign cs_n_s = sync2_q[3];
   assign di_s = sync2_q[1];
   assign se_n_s = sync2_q[0];
   // Link clock edges as seen in the system domain
   assign rise = sync2_q[2] & ~sclk_prev_q;
   assign fall = ~sync2_q[2] & sclk_prev_q;

   // ************************************************************
   // Channel decode
   // ************************************************************
   logic [3:0] mux_q;
   logic [3:0] word;
   logic sgl;
   logic odd;
   logic [1:0] sel;
   logic [2:0] pos_idx;
   logic [2:0] neg_idx;

   always_comb begin
      word = mux_q << ALIGN;
      sgl = word[SACL_SGL_POS];
      odd = word[SACL_ODD_POS];
      sel = word[1:0] >> ALIGN;
      pos_idx = sacl_chan(sel, odd);
      neg_idx = sacl_chan(sel, ~odd);
      // Fixed pair with fixed polarity on the single-channel part
      if (MW == 0) begin
         sgl = 1'b0;
         pos_idx = sacl_chan(2'b00, 1'b0);
         neg_idx = sacl_chan(2'b00, 1'b1);
      end
   end

   // ************************************************************
   // Comparator model
   // ************************************************************
   // Codes stand in for voltages, one step is reference / 256
   logic [3:0] cnt_q;
   sacl_code_t pos_q;
   sacl_code_t neg_q;
   sacl_code_t sar_q;
   sacl_code_t diff;
   sacl_code_t trial;
   logic decision;

   always_comb begin
      // Negative differential input clamps to code zero
      diff = (pos_q > neg_q) ? sacl_code_t'(pos_q - neg_q) : '0;
      trial = sar_q | (MSB_MASK >> cnt_q[2:0]);
      decision = (diff >= trial);
   end

   // ************************************************************
   // Transaction sequencer
   // ************************************************************
   sacl_state_t st_q;
   sacl_state_t st_d;
   logic [3:0] cnt_d;
   logic [3:0] mux_d;
   sacl_code_t pos_d;
   sacl_code_t neg_d;
   sacl_code_t sar_d;
   logic do_q;
   logic do_d;
   logic oe_q;
   logic oe_d;
   logic act_q;
   logic act_d;
   logic end_q;
   logic end_d;

   // Next state of the whole transaction
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      mux_d = mux_q;
      pos_d = pos_q;
      neg_d = neg_q;
      sar_d = sar_q;
      do_d = do_q;
      oe_d = oe_q;
      act_d = act_q;
      end_d = end_q;
      if (cs_n_s) begin
         st_d = ST_IDLE;
         cnt_d = '0;
         mux_d = '0;
         pos_d = '0;
         neg_d = '0;
         sar_d = '0;
         do_d = 1'b0;
         oe_d = 1'b0;
         act_d = 1'b0;
         end_d = 1'b0;
      end else begin
         if (rise && end_q) begin
            act_d = 1'b0;
         end
         case (st_q)
            ST_IDLE: begin
               if (rise && di_s) begin
                  cnt_d = '0;
                  if (MW == 0) begin
                     st_d = ST_SETTLE;
                     act_d = 1'b1;
                  end else begin
                     st_d = ST_ADDR;
                  end
               end
            end
            ST_ADDR: begin
               if (rise) begin
                  mux_d = {mux_q[2:0], di_s};
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == MW_LAST) begin
                     st_d = ST_SETTLE;
                     act_d = 1'b1;
                  end
               end
            end
            ST_SETTLE: begin
               if (fall) begin
                  oe_d = 1'b1;
                  do_d = 1'b0;
                  pos_d = analog_code[pos_idx];
                  cnt_d = '0;
                  sar_d = '0;
                  st_d = ST_CONV;
               end
            end
            ST_CONV: begin
               if (rise && cnt_q == 4'h0) begin
                  neg_d = sgl ? '0 : analog_code[neg_idx];
               end
               if (fall) begin
                  do_d = decision;
                  sar_d = decision ? trial : sar_q;
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == LAST_BIT) begin
                     st_d = ST_TAIL;
                     cnt_d = 4'h1;
                  end
               end
            end
            ST_TAIL: begin
               if (fall) begin
                  end_d = 1'b1;
                  if (VARIANT == SACL_VAR_SINGLE) begin
                     do_d = 1'b0;
                     st_d = ST_LOW;
                  end else if (VARIANT == SACL_VAR_AUTO || !se_n_s) begin
                     if (cnt_q == REPLAY_END) begin
                        do_d = 1'b0;
                        st_d = ST_LOW;
                     end else begin
                        do_d = sar_q[cnt_q[2:0]];
                        cnt_d = cnt_q + 4'h1;
                     end
                  end
               end
            end
            ST_LOW: begin
               do_d = 1'b0;
            end
            default: begin
               st_d = ST_IDLE;
            end
         endcase
      end
   end

   // Register the sequencer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         mux_q <= '0;
         pos_q <= '0;
         neg_q <= '0;
         sar_q <= '0;
         do_q <= 1'b0;
         oe_q <= 1'b0;
         act_q <= 1'b0;
         end_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         mux_q <= mux_d;
         pos_q <= pos_d;
         neg_q <= neg_d;
         sar_q <= sar_d;
         do_q <= do_d;
         oe_q <= oe_d;
         act_q <= act_d;
         end_q <= end_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign link.serial_out = do_q;
   assign link.serial_out_oe = oe_q;
   assign link.conversion_active = act_q;
   assign conv_result = sar_q;
endmodule : sacl_device
`default_nettype wire

/* pkg/sacl_pkg.sv */
// Shared constants and types for the serial converter link.
// Assumes a single 250 MHz system clock at both ends of the link.
package sacl_pkg;
   // ************************************************************
   // Widths and sizes
   // ************************************************************
   // Result width, 256 codes
   localparam int SACL_RES_BITS = 8;
   // Analog channels seen by the largest variant
   localparam int SACL_NUM_CH = 8;
   // Longest channel word
   localparam int SACL_MUX_MAX = 4;
   // Top bit of the aligned channel word is the mode bit
   localparam int SACL_SGL_POS = 3;
   // Next bit down is the polarity bit
   localparam int SACL_ODD_POS = 2;
   // Periods from the last address rise to the first result rise
   localparam int SACL_MSB_LEAD = 2;
   // Replayed bits after the result, bits 1 to 7
   localparam int SACL_REPLAY_BITS = 7;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int SACL_SYS_CLK_NS = 4;
   // Link clock period made by the host
   localparam int SACL_LINK_PERIOD_NS = 64;
   // System cycles per half link period, rounded down
   localparam int SACL_LINK_HALF_CYC = (SACL_LINK_PERIOD_NS / 2) / SACL_SYS_CLK_NS;
   // ************************************************************
   // Types
   // ************************************************************
   typedef logic [SACL_RES_BITS-1:0] sacl_code_t;
   // Product options of the converter
   typedef enum {SACL_VAR_SINGLE, SACL_VAR_AUTO, SACL_VAR_SE} sacl_variant_t;
endpackage : sacl_pkg

/* pkg/sacl_link_if.sv */
// Link wires between the converter and its controlling host.
// Assumes both ends sit on the same system clock; the bench may skew.
`timescale 1ns/1ps
`default_nettype none
interface sacl_link_if;
   // Select, low for a whole transaction
   logic conv_select_n;
   // Link clock, made by the host
   logic sclk;
   // Host to device data
   logic serial_in;
   // Host request for low-first replay, low active
   logic lsb_shift_enable_n;
   // Device to host data and its enable
   logic serial_out;
   logic serial_out_oe;
   // Conversion under way
   logic conversion_active;
   modport device (
      input conv_select_n, sclk, serial_in, lsb_shift_enable_n,
      output serial_out, serial_out_oe, conversion_active
   );
   modport host (
      output conv_select_n, sclk, serial_in, lsb_shift_enable_n,
      input serial_out, serial_out_oe, conversion_active
   );
endinterface : sacl_link_if
`default_nettype wire

/* hw/sacl_host.sv */
// Host end of the serial link: makes select and the link clock,
// sends start bit and channel word, gathers result and replay.
// Assumes the converter answers within three system cycles of an edge.
`timescale 1ns/1ps
`default_nettype none
module sacl_host #(
   parameter int MUX_BITS = sacl_pkg::SACL_MUX_MAX,
   parameter int HALF_CYC = sacl_pkg::SACL_LINK_HALF_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   sacl_link_if.host link,
   input wire logic start,
   input wire logic [sacl_pkg::SACL_MUX_MAX-1:0] mux_word,
   input wire logic replay_en,
   output logic busy,
   output logic done,
   output logic [sacl_pkg::SACL_RES_BITS-1:0] result,
   output logic [sacl_pkg::SACL_RES_BITS-1:0] replay_result
);
   import sacl_pkg::*;

   // ************************************************************
   // Local constants
   // ************************************************************
   localparam logic [4:0] M = 5'(MUX_BITS);
   localparam logic [4:0] FIRST_RD = 5'(MUX_BITS + SACL_MSB_LEAD);
   localparam logic [4:0] LSB_RD = 5'(MUX_BITS + SACL_MSB_LEAD + SACL_RES_BITS - 1);
   localparam logic [4:0] LAST_RD = 5'(MUX_BITS + SACL_MSB_LEAD + SACL_RES_BITS
                                       + SACL_REPLAY_BITS - 1);
   localparam logic [5:0] HALF_LAST = 6'(HALF_CYC - 1);
   localparam logic [2:0] ALIGN = 3'(SACL_MUX_MAX - MUX_BITS);

   typedef enum {H_IDLE, H_RUN} sacl_hstate_t;

   // ************************************************************
   // Return data synchroniser
   // ************************************************************
   logic do1_q;
   logic do2_q;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         do1_q <= 1'b0;
         do2_q <= 1'b0;
      end else begin
         do1_q <= link.serial_out;
         do2_q <= do1_q;
      end
   end

   // ************************************************************
   // Transaction engine
   // ************************************************************
   sacl_hstate_t st_q;
   sacl_hstate_t st_d;
   logic [5:0] div_q;
   logic [5:0] div_d;
   logic sclk_q;
   logic sclk_d;
   logic cs_n_q;
   logic cs_n_d;
   logic di_q;
   logic di_d;
   logic se_n_q;
   logic se_n_d;
   logic [4:0] per_q;
   logic [4:0] per_d;
   logic [3:0] word_q;
   logic [3:0] word_d;
   logic rep_q;
   logic rep_d;
   logic done_q;
   logic done_d;
   logic [7:0] res_q;
   logic [7:0] res_d;
   logic [7:0] rpl_q;
   logic [7:0] rpl_d;

   // Rising link edges are counted in per; data changes on falls
   always_comb begin
      st_d = st_q;
      div_d = div_q;
      sclk_d = sclk_q;
      cs_n_d = cs_n_q;
      di_d = di_q;
      se_n_d = se_n_q;
      per_d = per_q;
      word_d = word_q;
      rep_d = rep_q;
      done_d = 1'b0;
      res_d = res_q;
      rpl_d = rpl_q;
      case (st_q)
         H_IDLE: begin
            if (start) begin
               st_d = H_RUN;
               cs_n_d = 1'b0;
               di_d = 1'b1;
               div_d = '0;
               per_d = '0;
               word_d = mux_word << ALIGN;
               rep_d = replay_en;
            end
         end
         H_RUN: begin
            div_d = div_q + 6'h01;
            if (div_q == HALF_LAST) begin
               div_d = '0;
               sclk_d = ~sclk_q;
               if (!sclk_q) begin
                  // Rising edge: read the bit the device set on the fall
                  per_d = per_q + 5'h01;
                  if (per_q >= FIRST_RD && per_q <= LSB_RD) begin
                     res_d = {res_q[6:0], do2_q};
                  end
                  if (per_q >= LSB_RD) begin
                     rpl_d = {do2_q, rpl_q[7:1]};
                  end
                  if (per_q == LSB_RD && rep_q) begin
                     se_n_d = 1'b0;
                  end
               end else begin
                  di_d = (per_q <= M && per_q != 5'h00) ? word_q[SACL_MUX_MAX-1] : 1'b0;
                  if (per_q <= M && per_q != 5'h00) begin
                     word_d = word_q << 1;
                  end
                  if ((!rep_q && per_q > LSB_RD) || per_q > LAST_RD) begin
                     st_d = H_IDLE;
                     cs_n_d = 1'b1;
                     se_n_d = 1'b1;
                     sclk_d = 1'b0;
                     done_d = 1'b1;
                  end
               end
            end
         end
         default: begin
            st_d = H_IDLE;
         end
      endcase
   end

   // Register the engine
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_q <= H_IDLE;
         div_q <= '0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         di_q <= 1'b0;
         se_n_q <= 1'b1;
         per_q <= '0;
         word_q <= '0;
         rep_q <= 1'b0;
         done_q <= 1'b0;
         res_q <= '0;
         rpl_q <= '0;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         sclk_q <= sclk_d;
         cs_n_q <= cs_n_d;
         di_q <= di_d;
         se_n_q <= se_n_d;
         per_q <= per_d;
         word_q <= word_d;
         rep_q <= rep_d;
         done_q <= done_d;
         res_q <= res_d;
         rpl_q <= rpl_d;
      end
   end

   assign link.conv_select_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign link.serial_in = di_q;
   assign link.lsb_shift_enable_n = se_n_q;
   assign busy = (st_q == H_RUN);
   assign done = done_q;
   assign result = res_q;
   assign replay_result = rpl_q;
endmodule : sacl_host
`default_nettype wire

/* verification/sacl_link_asserts.sv */
// Concurrent checks on the converter link wires, device side.
// Assumes both ends share sys_clk and the host divider half period.
`timescale 1ns/1ps
`default_nettype none
module sacl_link_asserts #(
   parameter int HALF_CYC = 8
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic conv_select_n,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic lsb_shift_enable_n,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic conversion_active
);
   // Status stays up ten link periods, rise M to rise M+10
   localparam int ACT_CYC = 20 * HALF_CYC;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Cycles of status high so far
   logic [15:0] act_cnt_q;
   logic [15:0] act_cnt_d;
   // ************************************
   // Helper counter
   // ************************************
   // Cleared while status is low; a repetition would be far too long
   always_comb begin
      act_cnt_d = conversion_active ? act_cnt_q + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge sys_clk) begin
      act_cnt_q <= sys_rst ? 16'h0000 : act_cnt_d;
   end
   // ************************************
   // Assertions
   // ************************************
   a_active_on_rise: assert property ($rose(conversion_active) |-> sclk && !conv_select_n)
      else $error("status rose away from a link rising edge");
   a_settle_zero: assert property ($rose(conversion_active) |->
      (!serial_out_oe)[*4] ##[1:16] (serial_out_oe && !serial_out))
      else $error("no idle half period followed by a driven zero");
   a_drive_after_addr: assert property ($rose(serial_out_oe) |-> conversion_active && !sclk)
      else $error("output driven before channel assigned");
   a_out_on_fall: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
      |-> !sclk)
      else $error("output changed while link clock high");
   // A deselect may cut the status short; only a drop while selected is timed
   a_active_len: assert property ($fell(conversion_active) && !conv_select_n |->
      act_cnt_q >= 16'(ACT_CYC - 2) && act_cnt_q <= 16'(ACT_CYC + 2))
      else $error("status length differs from ten link periods");
   a_clear_on_desel: assert property (conv_select_n[*6] |-> !conversion_active)
      else $error("status kept while deselected");
   a_release_desel: assert property (conv_select_n[*6] |-> !serial_out_oe)
      else $error("output driven while deselected");
   a_hold_till_desel: assert property ($fell(serial_out_oe) |-> conv_select_n)
      else $error("output released while still selected");
   // Main scenarios reached
   c_conv: cover property ($fell(conversion_active));
   c_drive: cover property ($rose(serial_out_oe));
   c_replay: cover property (!lsb_shift_enable_n && serial_out_oe && !serial_in);
endmodule : sacl_link_asserts
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench: host and converter joined by the link interface.
// Assumes the default link half period; all three variants run side by side.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sacl_pkg::*;
   localparam int NTRIAL = 24;
   // Cycle ceiling, about three times the expected run
   localparam int LIMIT = 20000;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic start = 1'b0;
   logic [SACL_MUX_MAX-1:0] mux_word = 4'h0;
   logic replay_en = 1'b0;
   logic [SACL_NUM_CH-1:0][SACL_RES_BITS-1:0] analog_code = '0;
   logic busy;
   logic done;
   logic [7:0] result;
   logic [7:0] replay_result;
   logic [7:0] conv_result;
   // Wire bits seen on link rising edges while driven
   logic [15:0] wire_sh = 16'h0000;
   int wire_n = 0;
   logic sclk_q = 1'b0;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   sacl_link_if link ();
   always #2 sys_clk = ~sys_clk;
   sacl_device #(.VARIANT(SACL_VAR_SE), .MUX_BITS(SACL_MUX_MAX)) i_sacl_device (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link.device),
      .analog_code(analog_code), .conv_result(conv_result));
   sacl_host #(.MUX_BITS(SACL_MUX_MAX), .HALF_CYC(SACL_LINK_HALF_CYC)) i_sacl_host (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link.host), .start(start),
      .mux_word(mux_word), .replay_en(replay_en), .busy(busy), .done(done),
      .result(result), .replay_result(replay_result));
   sacl_link_asserts #(.HALF_CYC(SACL_LINK_HALF_CYC)) i_sacl_link_asserts (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .conv_select_n(link.conv_select_n),
      .sclk(link.sclk), .serial_in(link.serial_in),
      .lsb_shift_enable_n(link.lsb_shift_enable_n), .serial_out(link.serial_out),
      .serial_out_oe(link.serial_out_oe), .conversion_active(link.conversion_active));
   // Auto-replay and single-channel pairs share the stimulus of the main pair
   sacl_link_if link_a ();
   sacl_link_if link_s ();
   logic [7:0] result_a;
   logic [7:0] replay_a;
   logic [7:0] result_s;
   logic [7:0] replay_s;
   sacl_device #(.VARIANT(SACL_VAR_AUTO), .MUX_BITS(SACL_MUX_MAX)) i_sacl_device_auto (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_a.device),
      .analog_code(analog_code), .conv_result());
   sacl_host #(.MUX_BITS(SACL_MUX_MAX), .HALF_CYC(SACL_LINK_HALF_CYC)) i_sacl_host_auto (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_a.host), .start(start),
      .mux_word(mux_word), .replay_en(replay_en), .busy(), .done(),
      .result(result_a), .replay_result(replay_a));
   sacl_device #(.VARIANT(SACL_VAR_SINGLE), .MUX_BITS(0)) i_sacl_device_single (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_s.device),
      .analog_code(analog_code), .conv_result());
   sacl_host #(.MUX_BITS(0), .HALF_CYC(SACL_LINK_HALF_CYC)) i_sacl_host_single (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_s.host), .start(start),
      .mux_word(mux_word), .replay_en(replay_en), .busy(), .done(),
      .result(result_s), .replay_result(replay_s));
   // Wire monitor and hang guard
   always @(posedge sys_clk) begin
      sclk_q <= link.sclk;
      // Bit count restarts with each start pulse; no rise falls in that cycle
      if (start) begin
         wire_n <= 0;
      end else if (link.sclk && !sclk_q && link.serial_out_oe) begin
         wire_sh <= {wire_sh[14:0], link.serial_out};
         wire_n <= wire_n + 1;
      end
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         complete_run();
      end
   end
   // Expected code: positive minus negative, clamped at zero
   function automatic logic [7:0] exp_code(input logic [3:0] m,
         input logic [SACL_NUM_CH-1:0][SACL_RES_BITS-1:0] a);
      int ch;
      int d;
      ch = int'(m[1:0]) * 2 + int'(m[2]);
      d = m[3] ? int'(a[ch]) : int'(a[ch]) - int'(a[ch ^ 1]);
      return (d < 0) ? 8'h00 : 8'(d);
   endfunction : exp_code
   // Replayed bits 1 to 7 in wire order
   function automatic logic [6:0] rev7(input logic [7:0] v);
      return {v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
   endfunction : rev7
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // One conversion from start pulse to done, then idle checks
   task automatic run_trial(input logic [3:0] m, input logic rp);
      logic [7:0] e;
      logic [7:0] s;
      int w;
      e = exp_code(m, analog_code);
      // Single-channel part always converts the fixed pair
      s = exp_code(4'h0, analog_code);
      mux_word = m;
      replay_en = rp;
      start = 1'b1;
      @(posedge sys_clk);
      #1;
      start = 1'b0;
      check({15'h0000, busy}, 16'h0001);
      w = 0;
      while (done !== 1'b1 && w < 4000) begin
         @(posedge sys_clk);
         #1;
         w++;
      end
      check({8'h00, result}, {8'h00, e});
      check({8'h00, conv_result}, {8'h00, e});
      check({8'h00, result_a}, {8'h00, e});
      check({8'h00, result_s}, {8'h00, s});
      if (rp) begin
         check({8'h00, replay_a}, {8'h00, e});
         check({8'h00, replay_s}, {15'h0000, s[0]});
         check({8'h00, replay_result}, {8'h00, e});
         check(wire_sh, {1'b0, e, rev7(e)});
         check(16'(wire_n), 16'h0010);
      end else begin
         check({7'h00, wire_sh[8:0]}, {8'h00, e});
         check(16'(wire_n), 16'h0009);
      end
      repeat (8) @(posedge sys_clk);
      #1;
      check({13'h0000, busy, link.serial_out_oe, link.conversion_active}, 16'h0000);
   endtask : run_trial
   task automatic complete_run();
      if (err_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   // Every channel word first, then random ones; two level corners
   initial begin
      void'($urandom(32'hEB21));
      repeat (12) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      for (int i = 0; i < NTRIAL; i++) begin
         for (int c = 0; c < SACL_NUM_CH; c++) analog_code[c] = 8'($urandom);
         if (i == 0) analog_code = {SACL_NUM_CH{8'hFF}};
         if (i == 1) analog_code = '0;
         run_trial((i < 16) ? 4'(i) : 4'($urandom), 1'($urandom));
      end
      complete_run();
   end
endmodule : testbench
`default_nettype wire
